// >>> verilog/dtcu_pkg.sv
package dtcu_pkg;
    // ========================================================
    // register offsets on the special function register bus
    // ========================================================
    localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
    localparam logic [7:0] ADDR_TIMER_CONTROL  = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_SEL = 8'h89;
    localparam logic [7:0] ADDR_LOW_BYTE_CH0   = 8'h8A;
    localparam logic [7:0] ADDR_LOW_BYTE_CH1   = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_BYTE_CH0  = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_BYTE_CH1  = 8'h8D;

    // ========================================================
    // field positions
    // ========================================================
    localparam int TIMER_CONTROL_OVF_CH1 = 7;
    localparam int TIMER_CONTROL_RUN_CH1 = 6;
    localparam int TIMER_CONTROL_OVF_CH0 = 5;
    localparam int TIMER_CONTROL_RUN_CH0 = 4;
    localparam int TIMER_MODE_SELECT_GATE_CH1 = 7;
    localparam int TIMER_MODE_SELECT_SEL_CH1  = 6;
    localparam int TIMER_MODE_SELECT_MODE_CH1 = 4;
    localparam int TIMER_MODE_SELECT_GATE_CH0 = 3;
    localparam int TIMER_MODE_SELECT_SEL_CH0  = 2;
    localparam int TIMER_MODE_SELECT_MODE_CH0 = 0;
    localparam int POWER_CONTROL_STOP     = 1;
    localparam int POWER_CONTROL_SMOD     = 7;

    // ========================================================
    // reset values and timing
    // ========================================================
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CLK_PER_TICK = 12;

    typedef enum logic [1:0] {
        DTCU_MODE13,
        DTCU_MODE16,
        DTCU_RELOAD8,
        DTCU_SPLIT
    } dtcu_mode_t;
endpackage

// >>> verilog/dtcu_prescale.sv
module dtcu_prescale
    import dtcu_pkg::*;
#(
    parameter int DIV = CLK_PER_TICK
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic hold,
    // machine cycle tick
    output logic      tick
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // divide by twelve, frozen while held
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!hold) begin
            if (cnt_r == 4'(DIV - 1)) begin
                cnt_nxt  = 4'h0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r  <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule

// >>> verilog/dtcu_fall_detect.sv
module dtcu_fall_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // sampled level
    input  wire logic level,
    // one-cycle falling edge pulse
    output logic      fall
);
    logic prev_r;
    logic prev_nxt;
    logic fall_r;
    logic fall_nxt;

    // two samples needed, hence half-clock top rate
    always_comb begin
        prev_nxt = level;
        fall_nxt = prev_r & ~level;
    end

    // idle high, so a low level right after reset counts as an edge
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign fall = fall_r;
endmodule

// >>> verilog/dtcu_top.sv
module dtcu_top
    import dtcu_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // special function register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // gating inputs from digital pins
    input  wire logic       gating_input_ch0,
    input  wire logic       gating_input_ch1,
    // interrupt side
    input  wire logic       ovf_ack_ch0,
    input  wire logic       ovf_ack_ch1,
    input  wire logic       ext_irq,
    // status
    output logic            overflow_flag_ch0,
    output logic            overflow_flag_ch1,
    output logic            stop_active
);
    // ========================================================
    // state
    // ========================================================
    logic [7:0] power_control_r, power_control_nxt;
    logic [7:0] timer_mode_select_r, timer_mode_select_nxt;
    logic       run_bit_ch0_r, run_bit_ch0_nxt;
    logic       run_bit_ch1_r, run_bit_ch1_nxt;
    logic       ovf0_r, ovf0_nxt;
    logic       ovf1_r, ovf1_nxt;
    logic [7:0] low_byte_ch0_r, low_byte_ch0_nxt;
    logic [7:0] low_byte_ch1_r, low_byte_ch1_nxt;
    logic [7:0] high_byte_ch0_r, high_byte_ch0_nxt;
    logic [7:0] high_byte_ch1_r, high_byte_ch1_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    logic       tick;
    logic       fall0;
    logic       fall1;
    logic       stopped;

    // ========================================================
    // helpers
    // ========================================================
    // one count step in modes 00, 01, 10; returns {ovf, high, low}
    function automatic logic [16:0] step(input logic [1:0] mode,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [12:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13  = 13'h0000;
        c16  = 17'h00000;
        c8   = 9'h000;
        step = {1'b0, hi, lo};
        unique case (mode)
            2'b00: begin
                c13  = {hi, lo[4:0]} + 13'h0001;
                step = {(hi == 8'hFF) && (lo[4:0] == 5'h1F),
                        c13[12:5], 3'b000, c13[4:0]};
            end
            2'b01: begin
                c16  = {1'b0, hi, lo} + 17'h00001;
                step = c16;
            end
            2'b10: begin
                c8 = {1'b0, lo} + 9'h001;
                if (c8[8]) begin
                    step = {1'b1, hi, hi};
                end else begin
                    step = {1'b0, hi, c8[7:0]};
                end
            end
            2'b11: step = {1'b0, hi, lo};
        endcase
    endfunction

    // ========================================================
    // submodules
    // ========================================================
    dtcu_prescale #(.DIV(CLK_PER_TICK)) u_pre (
        .clk  (clk),
        .rst  (rst),
        .hold (stopped),
        .tick (tick)
    );

    dtcu_fall_detect u_fd0 (
        .clk   (clk),
        .rst   (rst),
        .level (gating_input_ch0),
        .fall  (fall0)
    );

    dtcu_fall_detect u_fd1 (
        .clk   (clk),
        .rst   (rst),
        .level (gating_input_ch1),
        .fall  (fall1)
    );

    assign stopped = power_control_r[POWER_CONTROL_STOP];

    // ========================================================
    // count enables
    // ========================================================
    logic [1:0] mode0, mode1;
    logic       ext0, ext1;
    logic       inc0, inc1, inc_th0_split;
    logic       split0;

    // external edges when select or gate set, else prescaled ticks
    always_comb begin
        mode0  = timer_mode_select_r[TIMER_MODE_SELECT_MODE_CH0 +: 2];
        mode1  = timer_mode_select_r[TIMER_MODE_SELECT_MODE_CH1 +: 2];
        ext0   = timer_mode_select_r[TIMER_MODE_SELECT_SEL_CH0] | timer_mode_select_r[TIMER_MODE_SELECT_GATE_CH0];
        ext1   = timer_mode_select_r[TIMER_MODE_SELECT_SEL_CH1] | timer_mode_select_r[TIMER_MODE_SELECT_GATE_CH1];
        split0 = (mode0 == 2'b11);
        // stop bit blocks every channel
        inc0 = run_bit_ch0_r && !stopped
               && (ext0 ? fall0 : tick);
        inc1 = run_bit_ch1_r && !stopped && (mode1 != 2'b11)
               && (ext1 ? fall1 : tick);
        // split high byte only times, on channel 1 run bit
        inc_th0_split = split0 && run_bit_ch1_r && !stopped
                        && tick;
    end

    // ========================================================
    // counters and flags
    // ========================================================
    logic [16:0] s0, s1;
    logic        ev0, ev1;
    logic        wr_timer_control;

    always_comb begin
        s0 = step(mode0, low_byte_ch0_r, high_byte_ch0_r);
        s1 = step(mode1, low_byte_ch1_r, high_byte_ch1_r);
        low_byte_ch0_nxt  = low_byte_ch0_r;
        high_byte_ch0_nxt = high_byte_ch0_r;
        low_byte_ch1_nxt  = low_byte_ch1_r;
        high_byte_ch1_nxt = high_byte_ch1_r;
        ev0 = 1'b0;
        ev1 = 1'b0;
        // channel 0: split halves or joint count
        if (split0) begin
            if (inc0) begin
                low_byte_ch0_nxt = low_byte_ch0_r + 8'h01;
                ev0 = (low_byte_ch0_r == 8'hFF);
            end
            if (inc_th0_split) begin
                high_byte_ch0_nxt = high_byte_ch0_r + 8'h01;
                ev1 = (high_byte_ch0_r == 8'hFF);
            end
        end else if (inc0) begin
            {high_byte_ch0_nxt, low_byte_ch0_nxt} = s0[15:0];
            ev0 = s0[16];
        end
        // channel 1 keeps counting in split, but its flag is lent out
        if (inc1) begin
            {high_byte_ch1_nxt, low_byte_ch1_nxt} = s1[15:0];
            if (!split0) begin
                ev1 = s1[16];
            end
        end
        // software writes win over counting
        if (sfr_wr) begin
            unique case (sfr_addr)
                ADDR_LOW_BYTE_CH0:  low_byte_ch0_nxt  = sfr_wdata;
                ADDR_LOW_BYTE_CH1:  low_byte_ch1_nxt  = sfr_wdata;
                ADDR_HIGH_BYTE_CH0: high_byte_ch0_nxt = sfr_wdata;
                ADDR_HIGH_BYTE_CH1: high_byte_ch1_nxt = sfr_wdata;
                default: ;
            endcase
        end
    end

    // flags: hardware set beats any clear in the same cycle
    always_comb begin
        wr_timer_control = sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL);
        run_bit_ch0_nxt = wr_timer_control ? sfr_wdata[TIMER_CONTROL_RUN_CH0]
                                  : run_bit_ch0_r;
        run_bit_ch1_nxt = wr_timer_control ? sfr_wdata[TIMER_CONTROL_RUN_CH1]
                                  : run_bit_ch1_r;
        ovf0_nxt = ovf0_r;
        ovf1_nxt = ovf1_r;
        if (ovf_ack_ch0) ovf0_nxt = 1'b0;
        if (ovf_ack_ch1) ovf1_nxt = 1'b0;
        if (wr_timer_control) begin
            ovf0_nxt = ovf0_nxt & sfr_wdata[TIMER_CONTROL_OVF_CH0];
            ovf1_nxt = ovf1_nxt & sfr_wdata[TIMER_CONTROL_OVF_CH1];
        end
        if (ev0) ovf0_nxt = 1'b1;
        if (ev1) ovf1_nxt = 1'b1;
    end

    // ========================================================
    // configuration registers
    // ========================================================
    // external interrupt releases stop, even against a write
    always_comb begin
        timer_mode_select_nxt = timer_mode_select_r;
        power_control_nxt = power_control_r;
        if (sfr_wr && sfr_addr == ADDR_TIMER_MODE_SEL) begin
            timer_mode_select_nxt = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ADDR_POWER_CONTROL) begin
            power_control_nxt = {sfr_wdata[POWER_CONTROL_SMOD], 5'h00,
                        sfr_wdata[POWER_CONTROL_STOP], 1'b0};
        end
        if (ext_irq) begin
            power_control_nxt[POWER_CONTROL_STOP] = 1'b0;
        end
    end

    // ========================================================
    // read path
    // ========================================================
    // unmapped addresses and reads without strobe return zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_POWER_CONTROL:  rdata_nxt = power_control_r;
                ADDR_TIMER_CONTROL:  rdata_nxt = {ovf1_r, run_bit_ch1_r,
                                                  ovf0_r, run_bit_ch0_r,
                                                  4'h0};
                ADDR_TIMER_MODE_SEL: rdata_nxt = timer_mode_select_r;
                ADDR_LOW_BYTE_CH0:   rdata_nxt = low_byte_ch0_r;
                ADDR_LOW_BYTE_CH1:   rdata_nxt = low_byte_ch1_r;
                ADDR_HIGH_BYTE_CH0:  rdata_nxt = high_byte_ch0_r;
                ADDR_HIGH_BYTE_CH1:  rdata_nxt = high_byte_ch1_r;
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // ========================================================
    // registers
    // ========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            power_control_r          <= RESET_BYTE;
            timer_mode_select_r          <= RESET_BYTE;
            run_bit_ch0_r   <= 1'b0;
            run_bit_ch1_r   <= 1'b0;
            ovf0_r          <= 1'b0;
            ovf1_r          <= 1'b0;
            low_byte_ch0_r  <= RESET_BYTE;
            low_byte_ch1_r  <= RESET_BYTE;
            high_byte_ch0_r <= RESET_BYTE;
            high_byte_ch1_r <= RESET_BYTE;
            rdata_r         <= RESET_BYTE;
        end else begin
            power_control_r          <= power_control_nxt;
            timer_mode_select_r          <= timer_mode_select_nxt;
            run_bit_ch0_r   <= run_bit_ch0_nxt;
            run_bit_ch1_r   <= run_bit_ch1_nxt;
            ovf0_r          <= ovf0_nxt;
            ovf1_r          <= ovf1_nxt;
            low_byte_ch0_r  <= low_byte_ch0_nxt;
            low_byte_ch1_r  <= low_byte_ch1_nxt;
            high_byte_ch0_r <= high_byte_ch0_nxt;
            high_byte_ch1_r <= high_byte_ch1_nxt;
            rdata_r         <= rdata_nxt;
        end
    end

    assign sfr_rdata         = rdata_r;
    assign overflow_flag_ch0 = ovf0_r;
    assign overflow_flag_ch1 = ovf1_r;
    assign stop_active       = power_control_r[POWER_CONTROL_STOP];
endmodule

// >>> verif/dtcu_pin_model.sv
module dtcu_pin_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // one request per wanted falling edge
    input  wire logic [1:0] fire,
    // pin levels, pulled up when idle
    output logic            gating_input_ch0,
    output logic            gating_input_ch1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] low_cnt_r [2];

    // low for two cycles, so the edge detector samples each low level twice
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (rst || low_cnt_r[i] == 2'h0) begin
                low_cnt_r[i] <= (!rst && fire[i]) ? 2'h2 : 2'h0;
            end else begin
                low_cnt_r[i] <= low_cnt_r[i] - 2'h1;
            end
        end
    end
    assign gating_input_ch0 = (low_cnt_r[0] == 2'h0);
    assign gating_input_ch1 = (low_cnt_r[1] == 2'h0);
endmodule

// >>> verif/dtcu_checker.sv
module dtcu_checker
    import dtcu_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // pins and status
    input wire logic       gating_input_ch0,
    input wire logic       gating_input_ch1,
    input wire logic       ovf_ack_ch0,
    input wire logic       ovf_ack_ch1,
    input wire logic       ext_irq,
    input wire logic       overflow_flag_ch0,
    input wire logic       overflow_flag_ch1,
    input wire logic       stop_active
);
    logic pc_wr;
    logic tc_wr;
    logic mapped;

    // decoded bus strobes
    assign pc_wr = sfr_wr && sfr_addr == ADDR_POWER_CONTROL;
    assign tc_wr = sfr_wr && sfr_addr == ADDR_TIMER_CONTROL;
    assign mapped = sfr_addr >= ADDR_POWER_CONTROL
                 && sfr_addr <= ADDR_HIGH_BYTE_CH1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ========================================================
    // bus and flag relations
    // ========================================================
    a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero without a read");
    a_unmapped_read: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_read_timer_control: assert property (sfr_rd && sfr_addr == ADDR_TIMER_CONTROL
        |=> sfr_rdata[3:0] == 4'h0 && sfr_rdata[5] == $past(overflow_flag_ch0)
        && sfr_rdata[7] == $past(overflow_flag_ch1))
        else $error("timer control read wrong");
    a_read_stop: assert property (sfr_rd && sfr_addr == ADDR_POWER_CONTROL
        |=> sfr_rdata[6:0] == {5'h00, $past(stop_active), 1'h0})
        else $error("power control read wrong");
    a_flag0_sticky: assert property (overflow_flag_ch0 && !ovf_ack_ch0
        && !(tc_wr && !sfr_wdata[TIMER_CONTROL_OVF_CH0]) |=> overflow_flag_ch0)
        else $error("flag 0 dropped without a clear");
    a_flag1_sticky: assert property (overflow_flag_ch1 && !ovf_ack_ch1
        && !(tc_wr && !sfr_wdata[TIMER_CONTROL_OVF_CH1]) |=> overflow_flag_ch1)
        else $error("flag 1 dropped without a clear");
    // stop control
    a_stop_set: assert property (pc_wr && sfr_wdata[POWER_CONTROL_STOP] && !ext_irq
        |=> stop_active)
        else $error("stop not entered");
    a_irq_wakes: assert property (ext_irq |=> !stop_active)
        else $error("stop not left on interrupt");
    a_stop_holds: assert property (stop_active && !ext_irq && !pc_wr
        |=> stop_active)
        else $error("stop left on its own");
    // flags cannot rise once the freeze has settled for two cycles
    a_stop_freeze: assert property ($past(stop_active, 2) && $past(stop_active)
        && stop_active |-> !$rose(overflow_flag_ch0) && !$rose(overflow_flag_ch1))
        else $error("overflow while stopped");
    c_stop: cover property ($rose(stop_active));
    c_flag0: cover property ($rose(overflow_flag_ch0));
    c_flag1: cover property ($rose(overflow_flag_ch1));
endmodule

bind dtcu_top dtcu_checker dtcu_checker_inst (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .gating_input_ch0(gating_input_ch0), .gating_input_ch1(gating_input_ch1),
    .ovf_ack_ch0(ovf_ack_ch0), .ovf_ack_ch1(ovf_ack_ch1), .ext_irq(ext_irq),
    .overflow_flag_ch0(overflow_flag_ch0),
    .overflow_flag_ch1(overflow_flag_ch1), .stop_active(stop_active)
);

// >>> verif/tb_dual_timer_counter_unit.sv
module tb_dual_timer_counter_unit
    import dtcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, sfr_wr, sfr_rd, ext_irq, ovf_ack_ch0, ovf_ack_ch1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0] fire;
    logic       gating_input_ch0, gating_input_ch1;
    logic       overflow_flag_ch0, overflow_flag_ch1, stop_active;
    int         fails, checked;

    dtcu_top dtcu_top_inst (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .gating_input_ch0(gating_input_ch0),
        .gating_input_ch1(gating_input_ch1), .ovf_ack_ch0(ovf_ack_ch0),
        .ovf_ack_ch1(ovf_ack_ch1), .ext_irq(ext_irq),
        .overflow_flag_ch0(overflow_flag_ch0),
        .overflow_flag_ch1(overflow_flag_ch1), .stop_active(stop_active));
    dtcu_pin_model dtcu_pin_model_inst (.clk(clk), .rst(rst), .fire(fire),
        .gating_input_ch0(gating_input_ch0),
        .gating_input_ch1(gating_input_ch1));

    // ========================================================
    // helpers
    // ========================================================
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs always move 1 ns after the edge
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // strobe dropped a cycle early so it is never set twice in one step
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        step(1);
        sfr_wr = 1'b0;
        step(1);
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp, string what);
        sfr_addr = a;
        sfr_rd = 1'b1;
        step(1);
        sfr_rd = 1'b0;
        chk(what, sfr_rdata, exp);
        step(1);
    endtask
    task automatic wait_flag(int ch, int lim, output int n);
        n = 0;
        while ((ch ? overflow_flag_ch1 : overflow_flag_ch0) !== 1'b1
               && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic pulse(int ch, int k);
        repeat (k) begin
            fire[ch] = 1'b1;
            step(1);
            fire[ch] = 1'b0;
            step(5);
        end
    endtask

    // ========================================================
    // scenarios
    // ========================================================
    task automatic t_regs();
        rdc(ADDR_POWER_CONTROL, 8'h00, "power_control");
        rdc(ADDR_TIMER_MODE_SEL, 8'h00, "timer_mode_select");
        wr(8'h90, 8'hFF);
        rdc(8'h90, 8'h00, "unmapped");
        wr(ADDR_TIMER_CONTROL, 8'hFF);
        rdc(ADDR_TIMER_CONTROL, 8'h50, "timer_control");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        $display("register test done");
    endtask
    task automatic t_modes();
        int n;
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_TIMER_MODE_SEL, 8'(m));
            wr(ADDR_HIGH_BYTE_CH0, 8'hFF);
            wr(ADDR_LOW_BYTE_CH0, m ? 8'hFF : 8'h1F);
            wr(ADDR_TIMER_CONTROL, 8'h10);
            wait_flag(0, 14, n);
            chk("wrap flag0", {7'h00, overflow_flag_ch0}, 8'h01);
            rdc(ADDR_LOW_BYTE_CH0, 8'h00, "low0 wrap");
            rdc(ADDR_HIGH_BYTE_CH0, 8'h00, "high0 wrap");
            wr(ADDR_TIMER_CONTROL, 8'h00);
        end
        $display("mode test done");
    endtask
    // two ticks per reload period, so spacing shows the tick rate
    task automatic t_reload();
        int n;
        wr(ADDR_TIMER_MODE_SEL, 8'h22);
        wr(ADDR_HIGH_BYTE_CH0, 8'hFE);
        wr(ADDR_LOW_BYTE_CH0, 8'hFE);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        wait_flag(0, 40, n);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        wait_flag(0, 40, n);
        chk("reload period", 8'(n + 2), 8'h18);
        rdc(ADDR_LOW_BYTE_CH0, 8'hFE, "reload value");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        $display("reload test done");
    endtask
    task automatic t_count();
        wr(ADDR_TIMER_MODE_SEL, 8'h51);
        wr(ADDR_LOW_BYTE_CH1, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        pulse(1, 3);
        rdc(ADDR_LOW_BYTE_CH1, 8'h03, "edge count ch1");
        wr(ADDR_TIMER_MODE_SEL, 8'h09);
        wr(ADDR_LOW_BYTE_CH0, 8'h00);
        pulse(0, 2);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        pulse(0, 2);
        rdc(ADDR_LOW_BYTE_CH0, 8'h02, "gated count ch0");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        $display("counter test done");
    endtask
    task automatic t_split();
        int n;
        wr(ADDR_TIMER_MODE_SEL, 8'h03);
        wr(ADDR_HIGH_BYTE_CH0, 8'hFF);
        wr(ADDR_LOW_BYTE_CH0, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        wait_flag(1, 14, n);
        chk("split flag1", {7'h00, overflow_flag_ch1}, 8'h01);
        chk("split flag0", {7'h00, overflow_flag_ch0}, 8'h00);
        ovf_ack_ch1 = 1'b1;
        step(1);
        ovf_ack_ch1 = 1'b0;
        chk("acked flag1", {7'h00, overflow_flag_ch1}, 8'h00);
        rdc(ADDR_LOW_BYTE_CH0, 8'h00, "split low0");
        wr(ADDR_TIMER_MODE_SEL, 8'h30);
        wr(ADDR_LOW_BYTE_CH1, 8'h05);
        step(30);
        rdc(ADDR_LOW_BYTE_CH1, 8'h05, "ch1 held");
        wr(ADDR_TIMER_CONTROL, 8'h00);
        $display("split test done");
    endtask
    task automatic t_stop();
        int n;
        wr(ADDR_TIMER_MODE_SEL, 8'h22);
        wr(ADDR_HIGH_BYTE_CH0, 8'hFE);
        wr(ADDR_LOW_BYTE_CH0, 8'hFE);
        wr(ADDR_TIMER_CONTROL, 8'h10);
        wr(ADDR_POWER_CONTROL, 8'h02);
        chk("stop", {7'h00, stop_active}, 8'h01);
        step(40);
        chk("frozen flag0", {7'h00, overflow_flag_ch0}, 8'h00);
        ext_irq = 1'b1;
        step(1);
        ext_irq = 1'b0;
        chk("woken", {7'h00, stop_active}, 8'h00);
        wait_flag(0, 30, n);
        chk("flag0 after wake", {7'h00, overflow_flag_ch0}, 8'h01);
        ovf_ack_ch0 = 1'b1;
        step(1);
        ovf_ack_ch0 = 1'b0;
        chk("acked flag0", {7'h00, overflow_flag_ch0}, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        $display("stop test done");
    endtask

    // clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog, well past the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {rst, sfr_wr, sfr_rd, ext_irq, ovf_ack_ch0, ovf_ack_ch1} = 6'h20;
        {sfr_addr, sfr_wdata, fire} = 18'h00000;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_regs();
        t_modes();
        t_reload();
        t_count();
        t_split();
        t_stop();
        tally_and_finish();
    end
endmodule
